// ### gag_glyph_addr.sv
// glyph address generator: command port decode, glyph base and config
// registers, glyph row loading and scan-time glyph fetch address.
// assumes host strobes arrive asynchronously, scan requests on clk_sys_in.
`timescale 1ns/1ns
module gag_glyph_addr
#(
   parameter int unsigned ADDR_WIDTH = 16
)
(
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   input wire logic ce_in,
   input wire logic host_wr_n_in,
   input wire logic host_a0_in,
   input wire logic [gag_pkg::GAG_DATA_W-1:0] host_data_in,
   input wire logic fetch_req_in,
   input wire logic [7:0] char_code_in,
   input wire logic [gag_pkg::GAG_ROW_W-1:0] row_select_in,
   input wire logic [gag_pkg::GAG_REG_W-1:0] reg_index_in,
   output logic [gag_pkg::GAG_REG_W-1:0] reg_data_out,
   output logic fetch_valid_out,
   output logic [ADDR_WIDTH-1:0] glyph_fetch_address_out,
   output logic fetch_from_ram_out,
   output logic fetch_blank_out,
   output logic mem_we_out,
   output logic [ADDR_WIDTH-1:0] mem_addr_out,
   output logic [gag_pkg::GAG_DATA_W-1:0] mem_wdata_out
);
   import gag_pkg::*;

   // ------------------------------------------------------------------
   // elaboration check
   // ------------------------------------------------------------------
   generate
      if (ADDR_WIDTH != GAG_ADDR_W)
      begin : g_bad_width
         $error("gag_glyph_addr: ADDR_WIDTH must be 16");
      end
   endgenerate

   // ------------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------------
   // code served by glyph RAM: the two RAM ranges, or all when ROM is off
   function automatic logic code_is_ram(input logic [7:0] code, input logic rom_off);
      code_is_ram = rom_off
         || (code >= GAG_RAM_RANGE0_LO && code <= GAG_RAM_RANGE0_HI)
         || (code >= GAG_RAM_RANGE1_LO && code <= GAG_RAM_RANGE1_HI);
   endfunction

   // base + shifted code + row; sum wraps at 16 bits like the memory space
   function automatic logic [15:0] ram_addr(input logic [15:0] base,
      input logic [7:0] code, input logic [3:0] row, input logic tall);
      logic [15:0] code_w;
      code_w = {8'h00, code};
      if (tall)
         ram_addr = base + (code_w << GAG_SHIFT_TALL) + {12'h000, row};
      else
         ram_addr = base + (code_w << GAG_SHIFT_SHORT) + {13'h0000, row[2:0]};
   endfunction

   // ------------------------------------------------------------------
   // host pin synchronisers
   // ------------------------------------------------------------------
   logic wr_n_s1_q, wr_n_s2_q, wr_n_s3_q;
   logic a0_s1_q, a0_s2_q;
   logic [GAG_DATA_W-1:0] data_s1_q, data_s2_q;
   logic cmd_stb, prm_stb;

   // two flops on every pin; a third wr stage only feeds the edge detect
   always_ff @(posedge clk_sys_in)
   begin
      if (!nrst_in)
      begin
         wr_n_s1_q <= 1'b1;
         wr_n_s2_q <= 1'b1;
         wr_n_s3_q <= 1'b1;
         a0_s1_q <= 1'b0;
         a0_s2_q <= 1'b0;
         data_s1_q <= '0;
         data_s2_q <= '0;
      end
      else if (ce_in)
      begin
         wr_n_s1_q <= host_wr_n_in;
         wr_n_s2_q <= wr_n_s1_q;
         wr_n_s3_q <= wr_n_s2_q;
         a0_s1_q <= host_a0_in;
         a0_s2_q <= a0_s1_q;
         data_s1_q <= host_data_in;
         data_s2_q <= data_s1_q;
      end
   end

   // act on the trailing edge of the write strobe, when data has settled
   assign cmd_stb = ce_in && wr_n_s2_q && !wr_n_s3_q && a0_s2_q;
   assign prm_stb = ce_in && wr_n_s2_q && !wr_n_s3_q && !a0_s2_q;

   // ------------------------------------------------------------------
   // command decoder
   // ------------------------------------------------------------------
   gag_mode_t mode_q;
   logic [GAG_PIDX_W-1:0] pidx_q;
   logic step_right_q;

   // a command byte opens a mode; parameter bytes count within it
   always_ff @(posedge clk_sys_in)
   begin
      if (!nrst_in)
      begin
         mode_q <= GAG_MODE_IDLE;
         pidx_q <= '0;
      end
      else if (cmd_stb)
      begin
         pidx_q <= '0;
         unique case (data_s2_q)
            GAG_CMD_SYSTEM_SET: mode_q <= GAG_MODE_SYSTEM_SET;
            GAG_CMD_SET_GLYPH_BASE: mode_q <= GAG_MODE_GLYPH_BASE;
            GAG_CMD_SET_CURSOR: mode_q <= GAG_MODE_CURSOR;
            GAG_CMD_MEMORY_WRITE: mode_q <= GAG_MODE_MEMORY_WRITE;
            default: mode_q <= GAG_MODE_IDLE;
         endcase
      end
      else if (prm_stb && pidx_q != '1)
      begin
         pidx_q <= pidx_q + 1'b1;
      end
   end

   // cursor stepping direction; only rightward stepping is known here
   always_ff @(posedge clk_sys_in)
   begin
      if (!nrst_in)
         step_right_q <= 1'b1;
      else if (cmd_stb && data_s2_q == GAG_CMD_CURSOR_STEP_RIGHT)
         step_right_q <= 1'b1;
   end

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   logic [7:0] system_config_q;
   logic [15:0] glyph_base_address_q;

   // first system-set parameter is the configuration byte
   always_ff @(posedge clk_sys_in)
   begin
      if (!nrst_in)
         system_config_q <= GAG_SYSTEM_CONFIG_RST;
      else if (prm_stb && mode_q == GAG_MODE_SYSTEM_SET && pidx_q == '0)
         system_config_q <= data_s2_q;
   end

   // glyph base: low byte then high byte; any value is accepted
   always_ff @(posedge clk_sys_in)
   begin
      if (!nrst_in)
         glyph_base_address_q <= GAG_GLYPH_BASE_RST;
      else if (prm_stb && mode_q == GAG_MODE_GLYPH_BASE)
      begin
         if (pidx_q == 3'd0)
            glyph_base_address_q[7:0] <= data_s2_q;
         else if (pidx_q == 3'd1)
            glyph_base_address_q[15:8] <= data_s2_q;
      end
   end

   // register readback, registered one clock later; unknown index reads zero
   always_ff @(posedge clk_sys_in)
   begin
      if (!nrst_in)
         reg_data_out <= '0;
      else if (ce_in)
      begin
         unique case (reg_index_in)
            GAG_REG_SYSTEM_CONFIG: reg_data_out <= system_config_q;
            GAG_REG_GLYPH_BASE_LOW: reg_data_out <= glyph_base_address_q[7:0];
            GAG_REG_GLYPH_BASE_HIGH: reg_data_out <= glyph_base_address_q[15:8];
            default: reg_data_out <= '0;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // cursor and glyph row loading
   // ------------------------------------------------------------------
   logic [15:0] cursor_q;

   // cursor set by two bytes, stepped after every memory write byte
   always_ff @(posedge clk_sys_in)
   begin
      if (!nrst_in)
         cursor_q <= GAG_CURSOR_RST;
      else if (prm_stb && mode_q == GAG_MODE_CURSOR && pidx_q == 3'd0)
         cursor_q[7:0] <= data_s2_q;
      else if (prm_stb && mode_q == GAG_MODE_CURSOR && pidx_q == 3'd1)
         cursor_q[15:8] <= data_s2_q;
      else if (prm_stb && mode_q == GAG_MODE_MEMORY_WRITE && step_right_q)
         cursor_q <= cursor_q + 16'h0001;
   end

   // each row byte goes out as a one-cycle display memory write
   always_ff @(posedge clk_sys_in)
   begin
      if (!nrst_in)
      begin
         mem_we_out <= 1'b0;
         mem_addr_out <= '0;
         mem_wdata_out <= '0;
      end
      else if (ce_in)
      begin
         mem_we_out <= prm_stb && mode_q == GAG_MODE_MEMORY_WRITE;
         if (prm_stb && mode_q == GAG_MODE_MEMORY_WRITE)
         begin
            mem_addr_out <= cursor_q;
            mem_wdata_out <= data_s2_q;
         end
      end
   end

   // ------------------------------------------------------------------
   // scan-time glyph fetch
   // ------------------------------------------------------------------
   logic rom_off, tall_cell, use_ram;
   assign rom_off = system_config_q[GAG_CFG_ROM_OFF_BIT];
   assign tall_cell = system_config_q[GAG_CFG_TALL_CELL_BIT];
   assign use_ram = code_is_ram(char_code_in, rom_off);

   // one fetch per request, answered on the next edge; ROM glyphs are
   // five wide by seven high, so rows from seven up come back blank
   always_ff @(posedge clk_sys_in)
   begin
      if (!nrst_in)
      begin
         fetch_valid_out <= 1'b0;
         glyph_fetch_address_out <= '0;
         fetch_from_ram_out <= 1'b0;
         fetch_blank_out <= 1'b0;
      end
      else if (ce_in)
      begin
         fetch_valid_out <= fetch_req_in;
         if (fetch_req_in)
         begin
            fetch_from_ram_out <= use_ram;
            if (use_ram)
            begin
               glyph_fetch_address_out <= ram_addr(glyph_base_address_q,
                  char_code_in, row_select_in, tall_cell);
               fetch_blank_out <= 1'b0;
            end
            else
            begin
               glyph_fetch_address_out <= {4'h0, char_code_in, row_select_in};
               fetch_blank_out <= row_select_in >= GAG_ROM_FONT_H;
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!nrst_in);

   property p_ram_short;
      fetch_req_in && ce_in && use_ram && !tall_cell |=>
         glyph_fetch_address_out == $past(glyph_base_address_q)
         + {5'h00, $past(char_code_in), 3'h0} + {13'h0000, $past(row_select_in[2:0])};
   endproperty
   a_ram_short: assert property (p_ram_short) else $error("short cell addr");

   property p_ram_tall;
      fetch_req_in && ce_in && use_ram && tall_cell |=>
         glyph_fetch_address_out == $past(glyph_base_address_q)
         + {4'h0, $past(char_code_in), 4'h0} + {12'h000, $past(row_select_in)};
   endproperty
   a_ram_tall: assert property (p_ram_tall) else $error("tall cell addr");

   property p_ram_ranges;
      fetch_req_in && ce_in && !rom_off && char_code_in inside {[8'h80:8'h9F], [8'hE0:8'hFF]}
         |=> fetch_from_ram_out;
   endproperty
   a_ram_ranges: assert property (p_ram_ranges) else $error("RAM range missed");

   property p_rom_ranges;
      fetch_req_in && ce_in && !rom_off
         && !(char_code_in inside {[8'h80:8'h9F], [8'hE0:8'hFF]}) |=> !fetch_from_ram_out;
   endproperty
   a_rom_ranges: assert property (p_rom_ranges) else $error("ROM code to RAM");

   property p_rom_off;
      fetch_req_in && ce_in && rom_off |=> fetch_from_ram_out && !fetch_blank_out;
   endproperty
   a_rom_off: assert property (p_rom_off) else $error("ROM off not RAM");

   property p_blank;
      fetch_req_in && ce_in && !use_ram |=> fetch_blank_out == ($past(row_select_in) >= 4'h7);
   endproperty
   a_blank: assert property (p_blank) else $error("ROM padding wrong");

   property p_base_low;
      prm_stb && mode_q == GAG_MODE_GLYPH_BASE && pidx_q == 3'h0 |=>
         glyph_base_address_q[7:0] == $past(data_s2_q);
   endproperty
   a_base_low: assert property (p_base_low) else $error("base low not loaded");

   property p_base_high;
      prm_stb && mode_q == GAG_MODE_GLYPH_BASE && pidx_q == 3'h1 |=>
         glyph_base_address_q[15:8] == $past(data_s2_q) && pidx_q == 3'h2;
   endproperty
   a_base_high: assert property (p_base_high) else $error("base high not loaded");

   property p_memory_write_cmd_step;
      prm_stb && mode_q == GAG_MODE_MEMORY_WRITE && step_right_q |=>
         mem_we_out && mem_addr_out == $past(cursor_q) && cursor_q == $past(cursor_q) + 16'h0001;
   endproperty
   a_memory_write_cmd_step: assert property (p_memory_write_cmd_step) else $error("row load step");

   property p_fetch_pulse;
      ce_in |=> fetch_valid_out == $past(fetch_req_in);
   endproperty
   a_fetch_pulse: assert property (p_fetch_pulse) else $error("stray fetch");

   c_tall_ram: cover property (fetch_valid_out && fetch_from_ram_out && tall_cell);
   c_rom_blank: cover property (fetch_valid_out && fetch_blank_out);
   c_row_load: cover property (mem_we_out ##[1:40] mem_we_out);
endmodule // gag_glyph_addr

// ### gag_host_model.sv
// host model: writes command and parameter bytes on the command port
// assumes the testbench calls send_byte from one process at a time
`timescale 1ns/1ns
module gag_host_model
(
   input wire logic clk_sys_in,
   output logic host_wr_n_out,
   output logic host_a0_out,
   output logic [7:0] host_data_out
);
   // idle bus: strobe high, data not left at a meaningful byte
   initial
   begin
      host_wr_n_out = 1'b1;
      host_a0_out = 1'b0;
      host_data_out = 8'hA5;
   end

   // -----------------------------------------------------------------
   // byte write: strobe low 3 cycles, data held 3 more, then let go
   // -----------------------------------------------------------------
   // the synchroniser needs 3 cycles each side, so slower is safe
   task automatic send_byte(input logic is_cmd, input logic [7:0] value);
      @(posedge clk_sys_in);
      host_a0_out <= is_cmd;
      host_data_out <= value;
      host_wr_n_out <= 1'b0;
      repeat (3) @(posedge clk_sys_in);
      host_wr_n_out <= 1'b1;
      repeat (3) @(posedge clk_sys_in);
      host_data_out <= ~value; // released bus must not look stable
      repeat (3) @(posedge clk_sys_in);
   endtask
endmodule // gag_host_model

// ### gag_pkg.sv
// constants for the glyph address generator: command codes, register
// offsets, config bit positions, code ranges and reset values.
// assumes a byte-wide host command port and a 16-bit display memory space.
//
// How it works
// - glyph RAM address is base plus code plus row
// - short cells: code at 10..3, row 2..0
// - tall cells: code at 11..4, row 3..0
// - config bit 2 picks 8x8 or 8x16 glyphs
// - codes 80h-9Fh, E0h-FFh come from glyph RAM
// - ROM has 160 5x7 glyphs, RAM 64
// - ROM glyph rows from seven up read blank
// - ROM in use lets base sit anywhere
// - ROM off: every code from RAM, base zero; the code still adds the loaded glyph base
// - eight lines single height, nine plus double
// - glyph rows load via 4Ch, 46h, 42h writes
package gag_pkg;
   // ------------------------------------------------------------------
   // widths
   // ------------------------------------------------------------------
   localparam int unsigned GAG_ADDR_W = 16;
   localparam int unsigned GAG_DATA_W = 8;
   localparam int unsigned GAG_ROW_W = 4;
   localparam int unsigned GAG_REG_W = 8;
   localparam int unsigned GAG_PIDX_W = 3;

   // ------------------------------------------------------------------
   // host command codes
   // ------------------------------------------------------------------
   localparam logic [7:0] GAG_CMD_SYSTEM_SET = 8'h40;
   localparam logic [7:0] GAG_CMD_SET_GLYPH_BASE = 8'h5C;
   localparam logic [7:0] GAG_CMD_CURSOR_STEP_RIGHT = 8'h4C;
   localparam logic [7:0] GAG_CMD_SET_CURSOR = 8'h46;
   localparam logic [7:0] GAG_CMD_MEMORY_WRITE = 8'h42;

   // ------------------------------------------------------------------
   // register offsets, fields and reset values
   // ------------------------------------------------------------------
   localparam logic [7:0] GAG_REG_SYSTEM_CONFIG = 8'h00;
   localparam logic [7:0] GAG_REG_GLYPH_BASE_LOW = 8'h19;
   localparam logic [7:0] GAG_REG_GLYPH_BASE_HIGH = 8'h1A;
   localparam int unsigned GAG_CFG_ROM_OFF_BIT = 0;
   localparam int unsigned GAG_CFG_TALL_CELL_BIT = 2;
   localparam logic [7:0] GAG_SYSTEM_CONFIG_RST = 8'h00;
   localparam logic [15:0] GAG_GLYPH_BASE_RST = 16'h0000;
   localparam logic [15:0] GAG_CURSOR_RST = 16'h0000;

   // ------------------------------------------------------------------
   // character code map and font geometry
   // ------------------------------------------------------------------
   localparam logic [7:0] GAG_RAM_RANGE0_LO = 8'h80;
   localparam logic [7:0] GAG_RAM_RANGE0_HI = 8'h9F;
   localparam logic [7:0] GAG_RAM_RANGE1_LO = 8'hE0;
   localparam logic [7:0] GAG_RAM_RANGE1_HI = 8'hFF;
   localparam int unsigned GAG_ROM_GLYPHS = 160;
   localparam int unsigned GAG_RAM_GLYPHS_MAX = 64;
   localparam logic [3:0] GAG_ROM_FONT_H = 4'h7;
   localparam int unsigned GAG_SHIFT_SHORT = 3;
   localparam int unsigned GAG_SHIFT_TALL = 4;

   // command decoder modes
   typedef enum logic [2:0]
   {
      GAG_MODE_IDLE,
      GAG_MODE_SYSTEM_SET,
      GAG_MODE_GLYPH_BASE,
      GAG_MODE_CURSOR,
      GAG_MODE_MEMORY_WRITE
   } gag_mode_t;
endpackage

// ### testbench.sv
// self-checking bench for the glyph address generator
// assumes gag_pkg and gag_host_model are compiled before this file
`timescale 1ns/1ns
module testbench;
   import gag_pkg::*;
   logic clk_sys_in, nrst_in, ce_in, fetch_req_in, host_wr_n_in, host_a0_in;
   logic [7:0] host_data_in, char_code_in, reg_index_in, reg_data_out, mem_wdata_out;
   logic [3:0] row_select_in;
   logic fetch_valid_out, fetch_from_ram_out, fetch_blank_out, mem_we_out;
   logic [15:0] glyph_fetch_address_out, mem_addr_out, exp_base;
   logic exp_tall, exp_rom_off;
   logic [23:0] wr_log[$];
   int bad_count = 0;
   int num_checks = 0;

   // -----------------------------------------------------------------
   // clock, design and host model
   // -----------------------------------------------------------------
   initial
   begin
      clk_sys_in = 1'b0;
      forever #10 clk_sys_in = ~clk_sys_in;
   end

   gag_glyph_addr #(.ADDR_WIDTH(16)) gag_glyph_addr_inst (
      .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .ce_in(ce_in),
      .host_wr_n_in(host_wr_n_in), .host_a0_in(host_a0_in), .host_data_in(host_data_in),
      .fetch_req_in(fetch_req_in), .char_code_in(char_code_in),
      .row_select_in(row_select_in), .reg_index_in(reg_index_in),
      .reg_data_out(reg_data_out), .fetch_valid_out(fetch_valid_out),
      .glyph_fetch_address_out(glyph_fetch_address_out),
      .fetch_from_ram_out(fetch_from_ram_out), .fetch_blank_out(fetch_blank_out),
      .mem_we_out(mem_we_out), .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out));

   gag_host_model gag_host_model_inst (
      .clk_sys_in(clk_sys_in), .host_wr_n_out(host_wr_n_in),
      .host_a0_out(host_a0_in), .host_data_out(host_data_in));

   // log every write pulse; it stands one cycle so one edge sees it
   always @(posedge clk_sys_in)
   begin
      if (mem_we_out === 1'b1)
         wr_log.push_back({mem_addr_out, mem_wdata_out});
   end

   // -----------------------------------------------------------------
   // shared tasks
   // -----------------------------------------------------------------
   task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
      num_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
      @(posedge clk_sys_in);
      reg_index_in <= idx;
      @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      check({16'h0000, reg_data_out}, {16'h0000, exp}, "register readback");
   endtask

   task automatic cmd(input logic [7:0] c, input logic [7:0] p1, input logic [7:0] p2,
                      input int n);
      gag_host_model_inst.send_byte(1'b1, c);
      if (n > 0)
         gag_host_model_inst.send_byte(1'b0, p1);
      if (n > 1)
         gag_host_model_inst.send_byte(1'b0, p2);
   endtask

   // config first, then base low and high, then read all three back
   task automatic set_cfg(input logic [7:0] cfg, input logic [15:0] base);
      cmd(GAG_CMD_SYSTEM_SET, cfg, 8'h00, 1);
      cmd(GAG_CMD_SET_GLYPH_BASE, base[7:0], base[15:8], 2);
      exp_tall = cfg[GAG_CFG_TALL_CELL_BIT];
      exp_rom_off = cfg[GAG_CFG_ROM_OFF_BIT];
      exp_base = base;
      rd(GAG_REG_SYSTEM_CONFIG, cfg);
      rd(GAG_REG_GLYPH_BASE_LOW, base[7:0]);
      rd(GAG_REG_GLYPH_BASE_HIGH, base[15:8]);
   endtask

   // request held high, so successive calls make back-to-back fetches
   task automatic fetch(input logic [7:0] code, input logic [3:0] row);
      logic ram;
      logic [15:0] ea;
      ram = exp_rom_off || (code inside {[8'h80:8'h9F], [8'hE0:8'hFF]});
      if (exp_tall)
         ea = exp_base + {4'h0, code, 4'h0} + row;
      else
         ea = exp_base + {5'h00, code, 3'h0} + row[2:0];
      if (!ram)
         ea = {4'h0, code, row};
      @(posedge clk_sys_in);
      fetch_req_in <= 1'b1;
      char_code_in <= code;
      row_select_in <= row;
      @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      check({fetch_valid_out, fetch_from_ram_out, fetch_blank_out, 5'h00,
             glyph_fetch_address_out}, {1'b1, ram, !ram && row >= 4'h7, 5'h00, ea}, "fetch");
   endtask

   task automatic idle();
      @(posedge clk_sys_in);
      fetch_req_in <= 1'b0;
   endtask

   // -----------------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------------
   task automatic t_reset();
      rd(GAG_REG_SYSTEM_CONFIG, 8'h00);
      rd(GAG_REG_GLYPH_BASE_HIGH, 8'h00);
      rd(8'h3C, 8'h00);
      check({fetch_valid_out, mem_we_out}, 24'h0, "outputs after reset");
   endtask

   task automatic t_short();
      logic [7:0] codes[8] = '{8'h80, 8'h9F, 8'hE0, 8'hFF, 8'h7F, 8'hA0, 8'hDF, 8'h00};
      logic [3:0] rows[8] = '{4'h5, 4'h7, 4'h0, 4'hF, 4'h6, 4'h7, 4'hF, 4'h0};
      set_cfg(8'h00, 16'h4000);
      foreach (codes[i])
         fetch(codes[i], rows[i]);
      idle();
   endtask

   task automatic t_tall();
      set_cfg(8'h04, 16'h1234);
      fetch(8'h81, 4'hF);
      fetch(8'hE5, 4'h9);
      fetch(8'h41, 4'h8);
      idle();
   endtask

   // with the ROM off the host keeps the base at zero
   task automatic t_rom_off();
      set_cfg(8'h01, 16'h0000);
      fetch(8'h41, 4'h3);
      fetch(8'h20, 4'h7);
      idle();
   endtask

   task automatic t_load();
      logic [7:0] rows[4] = '{8'h70, 8'h88, 8'hF8, 8'h00};
      wr_log.delete();
      cmd(GAG_CMD_CURSOR_STEP_RIGHT, 8'h00, 8'h00, 0);
      cmd(GAG_CMD_SET_CURSOR, 8'hFF, 8'h48, 2);
      cmd(GAG_CMD_MEMORY_WRITE, rows[0], rows[1], 2);
      gag_host_model_inst.send_byte(1'b0, rows[2]);
      gag_host_model_inst.send_byte(1'b0, rows[3]);
      check(wr_log.size(), 24'h000004, "write count");
      foreach (rows[i])
         if (i < wr_log.size())
            check(wr_log[i], {16'h48FF + i[15:0], rows[i]}, "glyph row write");
      // an unknown command idles the decoder, so its parameter writes nothing
      cmd(8'h99, 8'h55, 8'h00, 1);
      check(wr_log.size(), 24'h000004, "write after unknown command");
   endtask

   // clock enable low: a held request must neither answer nor move the address
   task automatic t_freeze();
      logic [15:0] held;
      held = glyph_fetch_address_out;
      @(posedge clk_sys_in);
      ce_in <= 1'b0;
      fetch_req_in <= 1'b1;
      char_code_in <= 8'h85;
      row_select_in <= 4'h2;
      repeat (3) @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      check({7'h00, fetch_valid_out, glyph_fetch_address_out}, {8'h00, held}, "frozen fetch");
      @(posedge clk_sys_in);
      ce_in <= 1'b1;
      fetch_req_in <= 1'b0;
   endtask

   // -----------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------
   initial
   begin
      nrst_in = 1'b0;
      ce_in = 1'b1;
      fetch_req_in = 1'b0;
      char_code_in = 8'h00;
      row_select_in = 4'h0;
      reg_index_in = 8'h00;
      exp_tall = 1'b0;
      exp_rom_off = 1'b0;
      exp_base = 16'h0000;
      repeat (6) @(posedge clk_sys_in);
      nrst_in <= 1'b1;
      t_reset();
      t_short();
      t_tall();
      t_rom_off();
      t_freeze();
      t_load();
      test_done();
   end
endmodule // testbench
